//--- shared/ursync_pkg.sv
package ursync_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0] STATUS_OFS  = 4'h0;
  localparam logic [3:0] CONTROL_OFS = 4'h4;
  localparam logic [3:0] FORMAT_OFS  = 4'h8;
  localparam logic [3:0] DATA_OFS    = 4'hC;
  localparam logic [3:0] BAUD_OFS    = 4'h0;

  // Status register bit positions
  localparam int PE_BIT  = 2;
  localparam int OVR_BIT = 3;
  localparam int FE_BIT  = 4;
  localparam int RXC_BIT = 7;
  localparam int DS_BIT  = 1;

  // Control register bit positions
  localparam int RXEN_BIT = 4;
  localparam int RXCIE_BIT = 7;

  // Frame format register bit positions
  localparam int STOP_BIT   = 3;
  localparam int PODD_BIT   = 4;
  localparam int PEN_BIT    = 5;
  localparam int SIZE_LSB   = 1;

  // Reset values
  localparam logic [7:0]  CONTROL_RST = 8'h00;
  localparam logic [7:0]  FORMAT_RST  = 8'h06;
  localparam logic [15:0] BAUD_RST    = 16'h0000;

  // Oversampling: samples per bit and vote centre; receive buffer depth
  localparam logic [3:0] NORM_LAST  = 4'hF;
  localparam logic [3:0] DBL_LAST   = 4'h7;
  localparam logic [3:0] NORM_VOTE0 = 4'h7;
  localparam logic [3:0] DBL_VOTE0  = 4'h3;
  localparam int         DEPTH      = 2;

  // One buffered character with its status
  typedef struct packed {
    logic       frameErr;
    logic       overrun;
    logic       parityErr;
    logic [7:0] data;
  } ursync_entry_t;

endpackage : ursync_pkg

//--- hw/ursync_baud_gen.sv
`timescale 1ns/1ns
module ursync_baud_gen
  import ursync_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Control
  input  wire logic        enable,
  input  wire logic [15:0] divisor,
  // Oversample strobe
  output      logic        sampleTick
);

  logic [15:0] countReg;

  // Divide ref_clk; tick every divisor+1 cycles
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      countReg   <= 16'h0000;
      sampleTick <= 1'b0;
    end
    else if (!enable)
    begin
      countReg   <= 16'h0000;
      sampleTick <= 1'b0;
    end
    else if (countReg >= divisor)
    begin
      countReg   <= 16'h0000;
      sampleTick <= 1'b1;
    end
    else
    begin
      countReg   <= countReg + 16'h0001;
      sampleTick <= 1'b0;
    end
  end

endmodule : ursync_baud_gen

//--- hw/ursync_rx_fifo.sv
`timescale 1ns/1ns
module ursync_rx_fifo
  import ursync_pkg::*;
(
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          reset_n,
  // Control
  input  wire logic          flush,
  input  wire logic          push,
  input  wire ursync_entry_t pushEntry,
  input  wire logic          pop,
  // State
  output      ursync_entry_t headEntry,
  output      logic          notEmpty,
  output      logic          full
);

  ursync_entry_t memArr [DEPTH];
  logic          wrPtr;
  logic          rdPtr;
  logic [1:0]    countReg;

  assign headEntry = memArr[rdPtr];
  assign notEmpty  = (countReg != 2'h0);
  assign full      = (countReg == 2'h2);

  // Pointers; flush drops all unread entries
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrPtr    <= 1'b0;
      rdPtr    <= 1'b0;
      countReg <= 2'h0;
    end
    else if (flush)
    begin
      wrPtr    <= 1'b0;
      rdPtr    <= 1'b0;
      countReg <= 2'h0; // [R2]
    end
    else
    begin
      if (push && !full)
        wrPtr <= ~wrPtr;
      if (pop && notEmpty)
        rdPtr <= ~rdPtr; // [R4]
      countReg <= countReg + {1'b0, push && !full}
                           - {1'b0, pop && notEmpty};
    end
  end

  // Storage; no reset needed on data
  always_ff @(posedge ref_clk)
  begin
    if (push && !full && !flush)
      memArr[wrPtr] <= pushEntry; // [R5]
  end

endmodule : ursync_rx_fifo

//--- hw/ursync_receiver.sv
`timescale 1ns/1ns
// Overview of operation
// [R1] Receive-complete set while buffer holds data
// [R2] Clearing enable flushes buffer, clears flag
// [R3] Interrupt requested while flag and enable
// [R4] Data read pops one character
// [R5] Error flags stored with each character
// [R6] Software writes to error flags ignored
// [R7] Software writes zero errors, reads status first
// [R8] Error flags never raise interrupts
// [R9] Frame error means first stop sampled zero
// [R10] Only first stop bit checked
// [R11] Overrun: buffer full, shifter full, start
// [R12] Overrun cleared on successful transfer
// [R13] Parity checked only when enabled, odd/even
// [R14] Parity result stored with character
// [R15] Parity error reads zero when disabled
// [R16] Disable abandons frame immediately
// [R17] Software flushes by reading until empty
// [R18] Sixteen samples per bit, eight double-speed
// [R19] Falling edge starts detection, sample one
// [R20] Vote start samples, reject noise
// [R21] Valid start resynchronises bit timing
// [R22] Odd select one means odd parity
// [R23] Each bit majority of centre samples
// [R24] Enable hands pin to receiver
module ursync_receiver
  import ursync_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Avalon-MM slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output      logic [31:0] readdata,
  output      logic        waitrequest,
  // Serial line
  input  wire logic        serialInputPin,
  // Status
  output      logic        rxIrq,
  output      logic        pinOverride
);

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_BITS  = 4'b0100,
    ST_HOLD  = 4'b1000
  } ursync_state_t;

  ursync_state_t stateReg;
  logic [7:0]    controlReg;
  logic [7:0]    formatReg;
  logic [15:0]   baudReg;
  logic          doubleSpeedReg;
  logic          ackReg;
  logic          overrunReg;
  logic          lineReg;
  logic [3:0]    phaseReg;
  logic [3:0]    bitIdxReg;
  logic [2:0]    voteReg;
  logic [8:0]    shiftReg;
  logic          parityErrReg;
  logic          stopErrReg;
  logic          pendingReg;
  ursync_entry_t holdEntry;
  ursync_entry_t headEntry;
  logic          sampleTick;
  logic          notEmpty;
  logic          full;
  logic          rxEnable;
  logic          parityOn;
  logic [3:0]    lastPhase;
  logic [3:0]    vote0;
  logic [3:0]    dataBits;
  logic [3:0]    frameBits;
  logic          popReq;
  logic          pushReq;
  logic          bitVal;
  logic          pushedFlag;

  // Majority of three samples
  function automatic logic majority(input logic [2:0] s);
    majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : majority

  assign rxEnable  = controlReg[RXEN_BIT];
  assign parityOn  = formatReg[PEN_BIT];
  assign lastPhase = doubleSpeedReg ? DBL_LAST : NORM_LAST; // [R18]
  assign vote0     = doubleSpeedReg ? DBL_VOTE0 : NORM_VOTE0; // [R20]
  // Size field 0..3 gives 5..8 data bits
  assign dataBits  = 4'h5 + {2'b00, formatReg[SIZE_LSB +: 2]};
  assign frameBits = dataBits + {3'b000, parityOn};
  assign bitVal    = majority(voteReg); // [R23]
  assign popReq    = read && ackReg && (address == DATA_OFS); // [R4]
  assign pushReq   = pendingReg && !full;

  ursync_baud_gen u_baud (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .enable     (rxEnable),
    .divisor    (baudReg),
    .sampleTick (sampleTick)
  );

  ursync_rx_fifo u_fifo (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .flush     (!rxEnable), // [R2]
    .push      (pushReq),
    .pushEntry (holdEntry),
    .pop       (popReq),
    .headEntry (headEntry),
    .notEmpty  (notEmpty),
    .full      (full)
  );

  // One wait cycle per access keeps read data registered
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ackReg      <= 1'b0;
      waitrequest <= 1'b1;
    end
    else
    begin
      ackReg      <= (read || write) && !ackReg;
      waitrequest <= !((read || write) && !ackReg);
    end
  end

  // Software registers; error positions are never stored
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      controlReg     <= CONTROL_RST;
      formatReg      <= FORMAT_RST;
      baudReg        <= BAUD_RST;
      doubleSpeedReg <= 1'b0;
    end
    else if (write && ackReg)
    begin
      case (address)
        STATUS_OFS:  doubleSpeedReg <= writedata[DS_BIT]; // [R6]
        CONTROL_OFS: controlReg <= writedata[7:0];
        FORMAT_OFS:  formatReg  <= writedata[7:0];
        DATA_OFS:    baudReg    <= writedata[31:16];
        default:     baudReg    <= baudReg;
      endcase
    end
  end

  // Read mux; error flags come from the head entry
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      readdata <= 32'h00000000;
    else if (read && !ackReg)
    begin
      readdata <= 32'h00000000;
      case (address)
        STATUS_OFS:
        begin
          readdata[RXC_BIT] <= notEmpty; // [R1]
          readdata[FE_BIT]  <= notEmpty && headEntry.frameErr; // [R9]
          readdata[OVR_BIT] <= notEmpty && headEntry.overrun;
          readdata[PE_BIT]  <= notEmpty && parityOn
                               && headEntry.parityErr; // [R15]
          readdata[DS_BIT]  <= doubleSpeedReg;
        end
        CONTROL_OFS: readdata[7:0] <= controlReg;
        FORMAT_OFS:  readdata[7:0] <= formatReg;
        DATA_OFS:
        begin
          readdata[7:0]   <= notEmpty ? headEntry.data : 8'h00;
          readdata[31:16] <= baudReg;
        end
        default:     readdata <= 32'h00000000;
      endcase
    end
  end

  // Interrupt only from receive-complete, never from errors
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rxIrq <= 1'b0;
    else
      rxIrq <= notEmpty && controlReg[RXCIE_BIT]; // [R3] [R8]
  end

  // Pin ownership follows the enable bit
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      pinOverride <= 1'b0;
    else
      pinOverride <= rxEnable; // [R24] [R16]
  end

  assign pushedFlag = pushReq;

  // Receive sequencer on oversample ticks
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stateReg     <= ST_IDLE;
      lineReg      <= 1'b1;
      phaseReg     <= 4'h0;
      bitIdxReg    <= 4'h0;
      voteReg      <= 3'b000;
      shiftReg     <= 9'h000;
      parityErrReg <= 1'b0;
      stopErrReg   <= 1'b0;
    end
    else if (!rxEnable)
    begin
      stateReg <= ST_IDLE; // [R16]
      lineReg  <= 1'b1;
    end
    else if (sampleTick)
    begin
      lineReg <= serialInputPin;
      // Collect the three centre samples of the bit
      if (phaseReg >= vote0 && phaseReg <= vote0 + 4'h2)
        voteReg <= {voteReg[1:0], serialInputPin};
      case (stateReg)
        ST_IDLE, ST_HOLD:
        begin
          if (lineReg && !serialInputPin)
          begin
            stateReg <= ST_START; // [R19]
            phaseReg <= 4'h1;
            shiftReg <= 9'h000; // Stale bits would spoil short parity
          end
        end
        ST_START:
        begin
          phaseReg <= phaseReg + 4'h1;
          if (phaseReg == vote0 + 4'h3)
          begin
            if (bitVal)
              stateReg <= ST_IDLE; // [R20]
          end
          if (phaseReg == lastPhase)
          begin
            stateReg  <= ST_BITS; // [R21]
            phaseReg  <= 4'h0;
            bitIdxReg <= 4'h0;
          end
        end
        ST_BITS:
        begin
          phaseReg <= phaseReg + 4'h1;
          if (phaseReg == vote0 + 4'h3)
          begin
            bitIdxReg <= bitIdxReg + 4'h1;
            if (bitIdxReg < dataBits)
              shiftReg <= {1'b0, bitVal, shiftReg[7:1]} >> 0;
            else if (bitIdxReg < frameBits)
              parityErrReg <= bitVal ^ formatReg[PODD_BIT]
                ^ (^shiftReg[7:0]); // [R13] [R22]
            else
            begin
              stopErrReg <= !bitVal; // [R9] [R10]
              stateReg   <= ST_HOLD;
            end
          end
          if (phaseReg == lastPhase)
            phaseReg <= 4'h0;
        end
        default: stateReg <= ST_IDLE;
      endcase
    end
  end

  // Right-justify short characters for the buffer
  function automatic logic [7:0] alignData(input logic [7:0] s,
                                           input logic [3:0] n);
    alignData = s >> (4'h8 - n);
  endfunction : alignData

  // Shifter full flag and overrun tracking
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pendingReg <= 1'b0;
      overrunReg <= 1'b0;
      holdEntry  <= '0;
    end
    else if (!rxEnable)
    begin
      pendingReg <= 1'b0;
      overrunReg <= 1'b0;
    end
    else
    begin
      if (sampleTick && stateReg == ST_BITS
          && phaseReg == vote0 + 4'h3 && bitIdxReg >= frameBits)
      begin
        if (!pendingReg || pushedFlag)
        begin
          pendingReg          <= 1'b1;
          holdEntry.data      <= alignData(shiftReg[7:0], dataBits);
          holdEntry.frameErr  <= !bitVal; // [R9]
          holdEntry.parityErr <= parityOn && parityErrReg; // [R14] [R15]
          holdEntry.overrun   <= overrunReg;
        end
      end
      else if (pushedFlag)
      begin
        pendingReg <= 1'b0;
        overrunReg <= 1'b0; // [R12]
      end
      // Full buffer, waiting character, new start: lose it
      if (sampleTick && pendingReg && full && !pushedFlag
          && (stateReg == ST_HOLD || stateReg == ST_IDLE)
          && lineReg && !serialInputPin)
      begin
        overrunReg <= 1'b1; // [R11]
        pendingReg <= 1'b0;
      end
    end
  end

  // Clearing enable empties the buffer and drops receive-complete
  AST_RXC_FLAG: assert property ( // [R2]
    @(posedge ref_clk) disable iff (!reset_n)
    !rxEnable |=> !notEmpty)
    else $error("buffer not flushed on disable");

  AST_IRQ_FOLLOWS: assert property ( // [R3]
    @(posedge ref_clk) disable iff (!reset_n)
    rxIrq == $past(notEmpty && controlReg[RXCIE_BIT]))
    else $error("interrupt does not follow flag");

  AST_POP_ONE: assert property ( // [R4]
    @(posedge ref_clk) disable iff (!reset_n)
    popReq && notEmpty && !pushReq && rxEnable
      |=> u_fifo.countReg == $past(u_fifo.countReg) - 2'h1)
    else $error("read did not remove one character");

  AST_PE_OFF: assert property ( // [R15]
    @(posedge ref_clk) disable iff (!reset_n)
    pushReq && !parityOn |-> !holdEntry.parityErr)
    else $error("parity error while checking off");

  AST_ABANDON: assert property ( // [R16]
    @(posedge ref_clk) disable iff (!reset_n)
    !rxEnable |=> stateReg == ST_IDLE && !pendingReg)
    else $error("frame not abandoned on disable");

  AST_OVR_CLR: assert property ( // [R12]
    @(posedge ref_clk) disable iff (!reset_n)
    pushReq && !(sampleTick && stateReg != ST_IDLE) && rxEnable
      |=> !overrunReg)
    else $error("overrun not cleared on transfer");

  AST_START_SEQ: assert property ( // [R19]
    @(posedge ref_clk) disable iff (!reset_n)
    sampleTick && rxEnable && stateReg == ST_IDLE && lineReg
      && !serialInputPin |=> stateReg == ST_START && phaseReg == 4'h1)
    else $error("start detect missed");

  AST_NOISE: assert property ( // [R20]
    @(posedge ref_clk) disable iff (!reset_n)
    sampleTick && rxEnable && stateReg == ST_START
      && phaseReg == vote0 + 4'h3 && bitVal |=> stateReg == ST_IDLE)
    else $error("noise start accepted");

  AST_PIN: assert property ( // [R24]
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(rxEnable) |=> pinOverride)
    else $error("pin not handed to receiver");

  COV_FRAME: cover property (@(posedge ref_clk) disable iff (!reset_n)
    pushReq);
  COV_OVERRUN: cover property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(overrunReg));
  COV_NOISE: cover property (@(posedge ref_clk) disable iff (!reset_n)
    stateReg == ST_START ##1 stateReg == ST_IDLE);

endmodule : ursync_receiver

//--- tb/ursync_tx_model.sv
`timescale 1ns/1ns
module ursync_tx_model
(
  // Clock
  input  wire logic ref_clk,
  // Serial line toward the receiver
  output      logic serialLine
);
  // Clocks per bit; the bench sets 8 for double speed
  int bitClks = 16;

  // Line idles at mark level
  initial serialLine = 1'b1;

  // Drive a level for n clocks, changed only right after an edge
  task automatic hold(input logic v, input int n);
    serialLine <= v;
    repeat (n) @(posedge ref_clk);
  endtask : hold

  // One frame, LSB first, optional parity, single stop bit
  task automatic send(input logic [7:0] d, input int nb, input logic pEn,
                      input logic pBit, input logic stopVal);
    @(posedge ref_clk);
    hold(1'b0, bitClks);
    for (int i = 0; i < nb; i++)
      hold(d[i], bitClks);
    if (pEn)
      hold(pBit, bitClks);
    hold(stopVal, bitClks);
    // Idle gap so the receiver can store the frame
    hold(1'b1, 2 * bitClks);
  endtask : send

  // Short low pulse, then idle long enough to cover a full frame
  task automatic glitch(input int n);
    @(posedge ref_clk);
    hold(1'b0, n);
    hold(1'b1, 12 * bitClks);
  endtask : glitch
endmodule : ursync_tx_model

//--- tb/testbench.sv
`timescale 1ns/1ns
module testbench
  import ursync_pkg::*;
  ;
  localparam logic [31:0] RXC = 32'h1 << RXC_BIT;
  localparam logic [31:0] FE  = 32'h1 << FE_BIT;
  localparam logic [31:0] OVR = 32'h1 << OVR_BIT;
  localparam logic [31:0] PE  = 32'h1 << PE_BIT;
  localparam logic [31:0] FLG = RXC | FE | OVR | PE;
  localparam logic [31:0] EN  = 32'h1 << RXEN_BIT;
  localparam logic [31:0] IE  = 32'h1 << RXCIE_BIT;
  localparam logic [31:0] FMT = {24'h0, FORMAT_RST};
  localparam logic [31:0] BY  = 32'h0000_00FF;

  logic        ref_clk     = 1'b0;
  logic        reset_n     = 1'b0;
  logic [3:0]  address     = 4'h0;
  logic        read        = 1'b0;
  logic        write       = 1'b0;
  logic [31:0] writedata   = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        serialLine;
  logic        rxIrq;
  logic        pinOverride;
  int          failCount   = 0;
  int          comparisons = 0;

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  ursync_receiver dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .serialInputPin(serialLine), .rxIrq(rxIrq), .pinOverride(pinOverride));

  ursync_tx_model tx (.ref_clk(ref_clk), .serialLine(serialLine));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failCount++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One Avalon cycle; request held until waitrequest is sampled low
  task automatic bus(input logic isWr, input logic [3:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge ref_clk);
    address   <= a;
    writedata <= wd;
    read      <= ~isWr;
    write     <= isWr;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0 && n < 20)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 20)
    begin
      failCount++;
      $display("CHECK FAILED t=%0t bus timeout", $time);
      finalReport();
    end
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask : wr

  task automatic rdchk(input logic [3:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk(v & m, e);
  endtask : rdchk

  // Outputs are sampled mid-cycle, away from their launching edge
  task automatic pins(input logic irq, input logic ovr);
    @(negedge ref_clk);
    chk({30'h0, rxIrq, pinOverride}, {30'h0, irq, ovr});
  endtask : pins

  task automatic testReset();
    rdchk(CONTROL_OFS, BY, {24'h0, CONTROL_RST});
    rdchk(FORMAT_OFS, BY, FMT);
    rdchk(STATUS_OFS, BY, 32'h0);
    rdchk(4'h1, 32'hFFFF_FFFF, 32'h0);
    wr(DATA_OFS, 32'h0);
    pins(1'b0, 1'b0);
    $display("Test reset done");
  endtask : testReset

  task automatic testBasic();
    logic [31:0] v;
    wr(CONTROL_OFS, EN | IE);
    tx.send(8'hA5, 8, 1'b0, 1'b0, 1'b1);
    rdchk(STATUS_OFS, FLG, RXC);
    pins(1'b1, 1'b1);
    rdchk(DATA_OFS, BY, 32'hA5);
    rdchk(STATUS_OFS, FLG, 32'h0);
    pins(1'b0, 1'b1);
    // Drain by reading data until the flag drops
    tx.send(8'h5A, 8, 1'b0, 1'b0, 1'b1);
    tx.send(8'h69, 8, 1'b0, 1'b0, 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b0, STATUS_OFS, 32'h0, v);
      if (v[RXC_BIT])
        bus(1'b0, DATA_OFS, 32'h0, v);
    end
    rdchk(STATUS_OFS, FLG, 32'h0);
    $display("Test basic done");
  endtask : testBasic

  task automatic testFrame();
    tx.send(8'h3C, 8, 1'b0, 1'b0, 1'b0);
    rdchk(STATUS_OFS, FLG, RXC | FE);
    wr(STATUS_OFS, 32'h0);
    rdchk(STATUS_OFS, FLG, RXC | FE);
    rdchk(DATA_OFS, BY, 32'h3C);
    wr(FORMAT_OFS, FMT | (32'h1 << STOP_BIT));
    tx.send(8'hC3, 8, 1'b0, 1'b0, 1'b1);
    rdchk(STATUS_OFS, FLG, RXC);
    rdchk(DATA_OFS, BY, 32'hC3);
    $display("Test frame done");
  endtask : testFrame

  task automatic testParity();
    logic [7:0] d;
    logic       odd;
    logic       bad;
    // Even and odd, with good and corrupted parity bit
    for (int i = 0; i < 4; i++)
    begin
      odd = i[1];
      bad = i[0];
      d = 8'h61 + 8'(i);
      wr(FORMAT_OFS, FMT | (32'h1 << PEN_BIT) | (32'(odd) << PODD_BIT));
      tx.send(d, 8, 1'b1, ^d ^ odd ^ bad, 1'b1);
      rdchk(STATUS_OFS, FLG, RXC | (bad ? PE : 32'h0));
      rdchk(DATA_OFS, BY, {24'h0, d});
    end
    // Bad odd parity stored, then hidden once checking is off
    tx.send(8'h0F, 8, 1'b1, 1'b0, 1'b1);
    wr(FORMAT_OFS, FMT);
    rdchk(STATUS_OFS, FLG, RXC);
    rdchk(DATA_OFS, BY, 32'h0F);
    wr(FORMAT_OFS, 32'h0);
    tx.send(8'h15, 5, 1'b0, 1'b0, 1'b1);
    rdchk(DATA_OFS, BY, 32'h15);
    wr(FORMAT_OFS, FMT);
    $display("Test parity done");
  endtask : testParity

  task automatic testOverrun();
    for (int i = 1; i < 5; i++)
      tx.send(8'(i), 8, 1'b0, 1'b0, 1'b1);
    rdchk(STATUS_OFS, FLG, RXC);
    rdchk(DATA_OFS, BY, 32'h01);
    rdchk(STATUS_OFS, FLG, RXC);
    rdchk(DATA_OFS, BY, 32'h02);
    rdchk(STATUS_OFS, FLG, RXC | OVR);
    rdchk(DATA_OFS, BY, 32'h04);
    tx.send(8'h05, 8, 1'b0, 1'b0, 1'b1);
    rdchk(STATUS_OFS, FLG, RXC);
    rdchk(DATA_OFS, BY, 32'h05);
    $display("Test overrun done");
  endtask : testOverrun

  task automatic testSync();
    int half;
    for (int ds = 0; ds < 2; ds++)
    begin
      wr(STATUS_OFS, 32'(ds) << DS_BIT);
      tx.bitClks = (ds == 1) ? 8 : 16;
      half = tx.bitClks / 2;
      rdchk(STATUS_OFS, 32'h1 << DS_BIT, 32'(ds) << DS_BIT);
      tx.glitch(half);
      rdchk(STATUS_OFS, FLG, 32'h0);
      tx.glitch(half + 1);
      rdchk(DATA_OFS, BY, 32'hFF);
      tx.send(8'h96, 8, 1'b0, 1'b0, 1'b1);
      rdchk(DATA_OFS, BY, 32'h96);
    end
    wr(STATUS_OFS, 32'h0);
    tx.bitClks = 16;
    $display("Test sync done");
  endtask : testSync

  task automatic testDisable();
    tx.send(8'h11, 8, 1'b0, 1'b0, 1'b1);
    // Disable lands in the middle of the second frame
    fork
      tx.send(8'h22, 8, 1'b0, 1'b0, 1'b1);
      begin
        repeat (80) @(posedge ref_clk);
        wr(CONTROL_OFS, 32'h0);
      end
    join
    pins(1'b0, 1'b0);
    wr(CONTROL_OFS, EN | IE);
    rdchk(STATUS_OFS, FLG, 32'h0);
    pins(1'b0, 1'b1);
    tx.send(8'h33, 8, 1'b0, 1'b0, 1'b1);
    rdchk(DATA_OFS, BY, 32'h33);
    $display("Test disable done");
  endtask : testDisable

  task automatic finalReport();
    $display("Comparisons %0d, failures %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finalReport

  // Main sequence
  initial
  begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    testReset();
    testBasic();
    testFrame();
    testParity();
    testOverrun();
    testSync();
    testDisable();
    finalReport();
  end

  // Watchdog, about six times the expected run
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    failCount++;
    finalReport();
  end
endmodule : testbench
